// ### design/bp_fet_ctrl.sv
// Purpose: battery protection registers, flags, lock and switch control
// Assumes: register strobes one cycle, inputs synchronous to clk_in
// Notes: read data appear the cycle after the read strobe, zero if unmapped
//
// Our own choice: the strobed register port.
`include "bp_params.svh"
`default_nettype none
module bp_fet_ctrl #(
  parameter int MS_CYCLES = `BP_MS_CYCLES
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // register port
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  // processor state
  input wire logic global_irq_en_in,
  input wire logic power_off_in,
  input wire logic timer_compare_b_pwm_in,
  // analogue protection inputs
  input wire logic charge_oc_active_in,
  input wire logic discharge_oc_active_in,
  input wire logic short_active_in,
  input wire logic monitored_supply_low_in,
  // interrupt and status
  output logic irq_out,
  output logic current_protection_out,
  output logic undervoltage_trip_out,
  output logic params_locked_out,
  // static configuration to the analogue side
  output logic [3:0] short_threshold_code_out,
  output logic [1:0] undervoltage_delay_code_out,
  output logic [3:0] undervoltage_level_code_out,
  // switch drives
  output logic charge_switch_drive_out,
  output logic discharge_switch_drive_out,
  output logic precharge_switch_drive_out
);
  import bp_pkg::*;

  // address match for one register
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  // total delay in ms for a delay code
  function automatic ms_count_t uv_delay_ms(input logic [1:0] code);
    uv_delay_ms = 11'(`BP_UV_BASE_MS) + 11'(`BP_UV_STEP_MS) * ms_count_t'(code);
  endfunction : uv_delay_ms

  // register state
  logic [3:0] flag_reg;
  logic [3:0] irq_en_reg;
  logic [3:0] short_code_reg;
  logic [1:0] uv_delay_reg;
  logic [3:0] uv_level_reg;
  logic charge_en_reg;
  logic discharge_en_reg;
  logic precharge_dis_reg;
  logic pwm_charge_reg;
  logic pwm_precharge_reg;
  logic [7:0] rdata_reg;
  logic irq_reg;

  // protection state
  logic current_prot_reg;
  logic uv_trip_reg;
  logic uv_warn_reg;
  logic chg_oc_prev_reg;
  logic dis_oc_prev_reg;
  logic short_prev_reg;

  // lock sequencer
  lock_state_t lock_state_reg;
  lock_state_t lock_state_next;
  logic [2:0] lock_win_reg;
  logic [2:0] lock_win_next;

  // decoded strobes
  logic wr_irq;
  logic wr_uvdl;
  logic wr_scl;
  logic wr_fet;
  logic wr_lock;
  logic locked;
  assign locked = (lock_state_reg == LOCK_DONE);
  assign wr_irq = wr_in & hit(addr_in, `BP_OFF_IRQ);
  assign wr_uvdl = wr_in & hit(addr_in, `BP_OFF_UVDL) & ~locked;
  assign wr_scl = wr_in & hit(addr_in, `BP_OFF_SCL) & ~locked;
  assign wr_fet = wr_in & hit(addr_in, `BP_OFF_FETCTL);
  assign wr_lock = wr_in & hit(addr_in, `BP_OFF_LOCK);

  // activation edges of the current protections
  logic chg_oc_rise;
  logic dis_oc_rise;
  logic short_rise;
  logic any_current_rise;
  assign chg_oc_rise = charge_oc_active_in & ~chg_oc_prev_reg;
  assign dis_oc_rise = discharge_oc_active_in & ~dis_oc_prev_reg;
  assign short_rise = short_active_in & ~short_prev_reg;
  assign any_current_rise = chg_oc_rise | dis_oc_rise | short_rise;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      chg_oc_prev_reg <= 1'b0;
      dis_oc_prev_reg <= 1'b0;
      short_prev_reg <= 1'b0;
    end else begin
      chg_oc_prev_reg <= charge_oc_active_in;
      dis_oc_prev_reg <= discharge_oc_active_in;
      short_prev_reg <= short_active_in;
    end
  end

  // hold-off timer runs while current protection is held
  ms_count_t holdoff_ms;
  bp_ms_timer #(
    .MS_CYCLES(MS_CYCLES)
  ) u_holdoff (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .run_in(current_prot_reg),
    .ms_out(holdoff_ms)
  );

  // a new activation during hold-off keeps the flag set but does not restart the timer or the second
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      current_prot_reg <= 1'b0;
    end else if (any_current_rise) begin
      current_prot_reg <= 1'b1;
    end else if (holdoff_ms >= 11'(`BP_HOLDOFF_MS)) begin
      current_prot_reg <= 1'b0;
    end
  end

  // deep under-voltage timer runs while supply stays low and power-off is not set
  ms_count_t uv_ms;
  logic uv_run;
  assign uv_run = monitored_supply_low_in & ~power_off_in;
  bp_ms_timer #(
    .MS_CYCLES(MS_CYCLES)
  ) u_uvtimer (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .run_in(uv_run),
    .ms_out(uv_ms)
  );

  // warning point is the selected delay less 250 ms
  logic uv_warn_now;
  assign uv_warn_now = uv_run
    & (uv_ms >= uv_delay_ms(uv_delay_reg) - 11'(`BP_UV_WARN_MS));

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      uv_warn_reg <= 1'b0;
      uv_trip_reg <= 1'b0;
    end else begin
      uv_warn_reg <= uv_warn_now;
      uv_trip_reg <= uv_run & (uv_ms >= uv_delay_ms(uv_delay_reg));
    end
  end

  // flag sources, index 3 warning down to 0 short
  logic [3:0] flag_set;
  assign flag_set = {uv_warn_now & ~uv_warn_reg,
                     chg_oc_rise,
                     dis_oc_rise,
                     short_rise};

  // write one clears, zero keeps, a same-cycle event wins over the clear
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      flag_reg <= 4'(`BP_RST_IRQ >> `BP_IRQ_FLAG_LSB);
    end else if (wr_irq) begin
      flag_reg <= (flag_reg & ~wdata_in[7:4]) | flag_set;
    end else begin
      flag_reg <= flag_reg | flag_set;
    end
  end

  // interrupt enables
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_en_reg <= 4'h0;
    end else if (wr_irq) begin
      irq_en_reg <= wdata_in[3:0];
    end
  end

  // single request line, registered so it comes from a flop
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= global_irq_en_in & (|(flag_reg & irq_en_reg));
    end
  end

  // parameter registers, frozen once locked
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      uv_delay_reg <= 2'h0;
      uv_level_reg <= 4'h0;
    end else if (wr_uvdl) begin
      uv_delay_reg <= wdata_in[5:4];
      uv_level_reg <= wdata_in[3:0];
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      short_code_reg <= 4'h0;
    end else if (wr_scl) begin
      short_code_reg <= wdata_in[3:0];
    end
  end

  // lock sequencer: arm, then confirm within the window
  always_comb begin
    lock_state_next = lock_state_reg;
    lock_win_next = lock_win_reg;
    case (lock_state_reg)
      LOCK_IDLE: begin
        if (wr_lock && wdata_in[1:0] == 2'b11) begin
          lock_state_next = LOCK_ARMED;
          lock_win_next = 3'(`BP_LOCK_WINDOW);
        end
      end
      LOCK_ARMED: begin
        if (wr_lock && wdata_in[1:0] == 2'b01) begin
          lock_state_next = LOCK_DONE;
        end else if (wr_lock && wdata_in[1:0] == 2'b11) begin
          lock_win_next = 3'(`BP_LOCK_WINDOW);
        end else if (wr_lock || lock_win_reg == 3'h1) begin
          lock_state_next = LOCK_IDLE;
          lock_win_next = 3'h0;
        end else begin
          lock_win_next = lock_win_reg - 3'h1;
        end
      end
      LOCK_DONE: begin
        lock_state_next = LOCK_DONE;
      end
      default: begin
        lock_state_next = LOCK_IDLE;
        lock_win_next = 3'h0;
      end
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      lock_state_reg <= LOCK_IDLE;
      lock_win_reg <= 3'h0;
    end else begin
      lock_state_reg <= lock_state_next;
      lock_win_reg <= lock_win_next;
    end
  end

  // software switch controls; a current-protection activation and power-off clear them
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      charge_en_reg <= 1'b0;
      discharge_en_reg <= 1'b0;
      precharge_dis_reg <= 1'b0;
    end else if (power_off_in) begin
      charge_en_reg <= 1'b0;
      discharge_en_reg <= 1'b0;
      precharge_dis_reg <= 1'b0;
    end else if (any_current_rise) begin
      charge_en_reg <= 1'b0;
      discharge_en_reg <= 1'b0;
      precharge_dis_reg <= 1'b0;
    end else if (wr_fet) begin
      // during hold-off software may turn enables off but never on
      charge_en_reg <= wdata_in[`BP_FET_CHG_EN] & ~current_prot_reg;
      discharge_en_reg <= wdata_in[`BP_FET_DIS_EN] & ~current_prot_reg;
      precharge_dis_reg <= wdata_in[`BP_FET_PRE_DIS];
    end
  end

  // pwm routing selects
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pwm_charge_reg <= 1'b0;
      pwm_precharge_reg <= 1'b0;
    end else if (wr_fet) begin
      pwm_charge_reg <= wdata_in[`BP_FET_PWM_CHG];
      pwm_precharge_reg <= wdata_in[`BP_FET_PWM_PRE];
    end
  end

  // drive gating, registered inside the gate
  bp_fet_gate u_gate (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .power_off_in(power_off_in),
    .current_prot_in(current_prot_reg),
    .uv_trip_in(uv_trip_reg),
    .charge_en_in(charge_en_reg),
    .discharge_en_in(discharge_en_reg),
    .precharge_dis_in(precharge_dis_reg),
    .pwm_charge_sel_in(pwm_charge_reg),
    .pwm_precharge_sel_in(pwm_precharge_reg),
    .pwm_in(timer_compare_b_pwm_in),
    .charge_drive_out(charge_switch_drive_out),
    .discharge_drive_out(discharge_switch_drive_out),
    .precharge_drive_out(precharge_switch_drive_out)
  );

  // read mux; unused high bits and unmapped addresses give zero
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    case (addr_in)
      `BP_OFF_IRQ: rd_mux = {flag_reg, irq_en_reg};
      `BP_OFF_UVDL: rd_mux = {2'b00, uv_delay_reg, uv_level_reg};
      `BP_OFF_SCL: rd_mux = {4'h0, short_code_reg};
      `BP_OFF_LOCK: rd_mux = {6'h00, lock_state_reg == LOCK_ARMED, locked};
      `BP_OFF_FETCTL: rd_mux = {2'b00, pwm_charge_reg, pwm_precharge_reg,
                                current_prot_reg, discharge_en_reg,
                                charge_en_reg, precharge_dis_reg};
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_reg <= 8'h00;
    end else if (rd_in) begin
      rdata_reg <= rd_mux;
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  // outputs straight from flops, except the lock status decoded from the lock state flops
  assign rdata_out = rdata_reg;
  assign irq_out = irq_reg;
  assign current_protection_out = current_prot_reg;
  assign undervoltage_trip_out = uv_trip_reg;
  assign params_locked_out = locked;
  assign short_threshold_code_out = short_code_reg;
  assign undervoltage_delay_code_out = uv_delay_reg;
  assign undervoltage_level_code_out = uv_level_reg;
endmodule : bp_fet_ctrl
`default_nettype wire

// ### design/bp_params.svh
// Purpose: constants for the battery protection and switch control block
// Assumes: 8-bit register port, 250 MHz clock
// Notes: offsets are byte addresses on the plain register port
`ifndef BP_PARAMS_SVH
`define BP_PARAMS_SVH

// register offsets
`define BP_OFF_LOCK 8'hF0
`define BP_OFF_FETCTL 8'hF1
`define BP_OFF_IRQ 8'hF2
`define BP_OFF_UVDL 8'hF3
`define BP_OFF_SCL 8'hF6

// reset values
`define BP_RST_IRQ 8'h00
`define BP_RST_UVDL 8'h00
`define BP_RST_SCL 8'h00
`define BP_RST_FETCTL 8'h00

// field positions
`define BP_IRQ_FLAG_LSB 4
`define BP_UV_DELAY_LSB 4
`define BP_LOCK_BIT 0
`define BP_LOCK_ARM_BIT 1
`define BP_FET_PRE_DIS 0
`define BP_FET_CHG_EN 1
`define BP_FET_DIS_EN 2
`define BP_FET_CP_STAT 3
`define BP_FET_PWM_PRE 4
`define BP_FET_PWM_CHG 5
`define BP_UVDL_MASK 8'h3F
`define BP_NIB_MASK 8'h0F
`define BP_FETCTL_MASK 8'h37

// timing
`define BP_CLK_HZ 250000000
`define BP_MS_CYCLES (`BP_CLK_HZ / 1000)
`define BP_HOLDOFF_MS 1000
`define BP_UV_BASE_MS 750
`define BP_UV_STEP_MS 250
`define BP_UV_WARN_MS 250
`define BP_LOCK_WINDOW 4

`endif

// ### design/bp_pkg.sv
// Purpose: shared types for the battery protection block
// Assumes: nothing beyond the constants header
// Notes: lock sequencer states are one-hot
`default_nettype none
package bp_pkg;
  typedef enum logic [2:0] {
    LOCK_IDLE = 3'b001,
    LOCK_ARMED = 3'b010,
    LOCK_DONE = 3'b100
  } lock_state_t;
  typedef logic [10:0] ms_count_t;
endpackage : bp_pkg
`default_nettype wire

// ### design/bp_ms_timer.sv
// Purpose: millisecond elapsed-time counter that runs while enabled
// Assumes: MS_CYCLES clock cycles per millisecond
// Notes: clears at once when run drops; count saturates
`default_nettype none
module bp_ms_timer #(
  parameter int MS_CYCLES = 250000
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // control and count
  input wire logic run_in,
  output bp_pkg::ms_count_t ms_out
);
  import bp_pkg::*;
  localparam int PW = $clog2(MS_CYCLES + 1);
  logic [PW-1:0] pre_reg;
  ms_count_t ms_reg;

  // prescaler and saturating millisecond count
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pre_reg <= '0;
      ms_reg <= '0;
    end else if (!run_in) begin
      pre_reg <= '0;
      ms_reg <= '0;
    end else if (pre_reg == PW'(MS_CYCLES - 1)) begin
      pre_reg <= '0;
      if (ms_reg != '1) begin
        ms_reg <= ms_reg + 11'h001;
      end
    end else begin
      pre_reg <= pre_reg + PW'(1);
    end
  end

  assign ms_out = ms_reg;
endmodule : bp_ms_timer
`default_nettype wire

// ### design/bp_fet_gate.sv
// Purpose: registered gating of the three switch drives
// Assumes: all inputs synchronous to clk_in
// Notes: power-off overrides all drives; current protection overrides charge, discharge and pwm; under-voltage trip only discharge
`default_nettype none
module bp_fet_gate (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // protection state
  input wire logic power_off_in,
  input wire logic current_prot_in,
  input wire logic uv_trip_in,
  // software controls
  input wire logic charge_en_in,
  input wire logic discharge_en_in,
  input wire logic precharge_dis_in,
  input wire logic pwm_charge_sel_in,
  input wire logic pwm_precharge_sel_in,
  input wire logic pwm_in,
  // drives
  output logic charge_drive_out,
  output logic discharge_drive_out,
  output logic precharge_drive_out
);
  logic pwm_ok;
  assign pwm_ok = pwm_in & ~current_prot_in;

  // protection terms are ANDed last so no control can override them
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      charge_drive_out <= 1'b0;
      discharge_drive_out <= 1'b0;
      precharge_drive_out <= 1'b0;
    end else begin
      charge_drive_out <= ~power_off_in & ~current_prot_in
        & (pwm_charge_sel_in ? pwm_ok : charge_en_in);
      discharge_drive_out <= ~power_off_in & ~current_prot_in & ~uv_trip_in
        & discharge_en_in;
      precharge_drive_out <= ~power_off_in
        & (pwm_precharge_sel_in ? pwm_ok : ~precharge_dis_in);
    end
  end
endmodule : bp_fet_gate
`default_nettype wire

// ### verif/fet_switch_model.sv
// Purpose: external charge, discharge and precharge switches
// Assumes: drive high turns a switch on
// Notes: turn-on takes ON_DLY+1 clocks, turn-off is at once
`default_nettype none
module fet_switch_model #(
  parameter int ON_DLY = 2
) (
  // clock
  input wire logic clk_in,
  // gate drives, charge in bit 0
  input wire logic [2:0] drive_in,
  // conduction state
  output logic [2:0] on_out = 3'h0
);
  timeunit 1ns;
  timeprecision 1ps;
  int age [3] = '{0, 0, 0};
  // gate charges slowly but is dumped at once, so a cut is never late
  always @(posedge clk_in) begin
    for (int i = 0; i < 3; i++) begin
      age[i] = drive_in[i] ? age[i] + 1 : 0;
      on_out[i] <= drive_in[i] && age[i] > ON_DLY;
    end
  end
endmodule : fet_switch_model
`default_nettype wire

// ### verif/bp_fet_ctrl_assertions.sv
// Purpose: port-level checks of the protection block
// Assumes: MS_CYCLES equals the bound instance
// Notes: hold-off span is judged with a small counter
`default_nettype none
module bp_fet_ctrl_assertions #(
  parameter int MS_CYCLES = 10
) (
  // clock, reset, register port
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] rdata_out,
  // processor and protection inputs
  input wire logic global_irq_en_in,
  input wire logic power_off_in,
  input wire logic charge_oc_active_in,
  input wire logic discharge_oc_active_in,
  input wire logic short_active_in,
  // status, config and drives
  input wire logic irq_out,
  input wire logic current_protection_out,
  input wire logic params_locked_out,
  input wire logic [3:0] short_threshold_code_out,
  input wire logic [3:0] undervoltage_level_code_out,
  input wire logic charge_switch_drive_out,
  input wire logic discharge_switch_drive_out,
  input wire logic precharge_switch_drive_out
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HOLD = 1000 * MS_CYCLES;
  int hold_cnt;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // the count restarts on a fresh activation, though the block's hold-off span does not
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in)
      hold_cnt <= 0;
    else if (!current_protection_out || $rose(short_active_in) ||
             $rose(charge_oc_active_in) || $rose(discharge_oc_active_in))
      hold_cnt <= 0;
    else
      hold_cnt <= hold_cnt + 1;
  end
  sequence lock_arm;
    wr_in && addr_in == 8'hF0 && wdata_in == 8'h03;
  endsequence
  sequence lock_fire;
    wr_in && addr_in == 8'hF0 && wdata_in == 8'h01;
  endsequence
  a_lock_order: assert property (lock_arm ##1 !wr_in ##1 lock_fire |-> ##[1:2] params_locked_out)
    else $error("lock sequence did not lock");
  a_lock_sticks: assert property (params_locked_out |=> params_locked_out)
    else $error("lock dropped");
  a_lock_freeze: assert property (params_locked_out ##1 params_locked_out |=>
    $stable(short_threshold_code_out) && $stable(undervoltage_level_code_out))
    else $error("locked setting changed");
  a_short_upper_zero: assert property (rd_in && addr_in == 8'hF6 |=> rdata_out[7:4] == 4'h0)
    else $error("short level upper bits not zero");
  a_off_all_low: assert property (power_off_in |=> !charge_switch_drive_out &&
    !discharge_switch_drive_out && !precharge_switch_drive_out)
    else $error("drive on in power-off");
  a_hold_blocks: assert property (current_protection_out |=> !charge_switch_drive_out &&
    !discharge_switch_drive_out)
    else $error("drive on during hold-off");
  a_wake_held_off: assert property ($fell(power_off_in) |->
    !discharge_switch_drive_out ##1 !discharge_switch_drive_out)
    else $error("discharge on at wake");
  a_irq_gated: assert property (!global_irq_en_in |=> !irq_out)
    else $error("irq without global enable");
  a_short_holdoff: assert property ($rose(short_active_in) |-> ##[1:2] current_protection_out)
    else $error("short did not start hold-off");
  a_hold_span: assert property ($fell(current_protection_out) |->
    hold_cnt >= HOLD - 3 && hold_cnt <= HOLD + 3)
    else $error("hold-off length wrong");
  a_hold_bound: assert property (hold_cnt <= HOLD + 3)
    else $error("hold-off overran");
endmodule : bp_fet_ctrl_assertions
bind bp_fet_ctrl bp_fet_ctrl_assertions #(.MS_CYCLES(MS_CYCLES)) bp_fet_ctrl_assertions_i (
  .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
  .global_irq_en_in(global_irq_en_in), .power_off_in(power_off_in),
  .charge_oc_active_in(charge_oc_active_in), .discharge_oc_active_in(discharge_oc_active_in),
  .short_active_in(short_active_in), .irq_out(irq_out),
  .current_protection_out(current_protection_out), .params_locked_out(params_locked_out),
  .short_threshold_code_out(short_threshold_code_out),
  .undervoltage_level_code_out(undervoltage_level_code_out),
  .charge_switch_drive_out(charge_switch_drive_out),
  .discharge_switch_drive_out(discharge_switch_drive_out),
  .precharge_switch_drive_out(precharge_switch_drive_out));
`default_nettype wire

// ### verif/bp_fet_ctrl_tb.sv
// Purpose: self-checking bench for the protection block
// Assumes: MS_CYCLES of 10, one millisecond is ten clocks
// Notes: lock runs last; a second reset must undo it
`default_nettype none
module bp_fet_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MS = 10;
  logic clk_in = 0, rst_in = 1, wr_in = 0, rd_in = 0, gie = 0, poff = 0, pwm = 0, low = 0;
  logic [7:0] addr_in = 8'h00, wdata_in = 8'h00, rdata_out, d;
  logic [2:0] act = 3'h0, drv, sw;
  logic irq, cp, trip, lck;
  logic [3:0] sc_code, lv_code;
  logic [1:0] dl_code;
  int bad_count = 0, tests_run = 0, cyc_cnt = 0, t0;
  bp_fet_ctrl #(.MS_CYCLES(MS)) bp_fet_ctrl_i (.clk_in(clk_in), .rst_in(rst_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .global_irq_en_in(gie), .power_off_in(poff),
    .timer_compare_b_pwm_in(pwm), .charge_oc_active_in(act[0]),
    .discharge_oc_active_in(act[1]), .short_active_in(act[2]), .monitored_supply_low_in(low),
    .irq_out(irq), .current_protection_out(cp), .undervoltage_trip_out(trip),
    .params_locked_out(lck), .short_threshold_code_out(sc_code),
    .undervoltage_delay_code_out(dl_code), .undervoltage_level_code_out(lv_code),
    .charge_switch_drive_out(drv[0]), .discharge_switch_drive_out(drv[1]),
    .precharge_switch_drive_out(drv[2]));
  fet_switch_model #(.ON_DLY(2)) fet_switch_model_i (.clk_in(clk_in), .drive_in(drv),
    .on_out(sw));
  // 250 MHz clock and a cycle count for timing checks
  initial forever #2 clk_in = ~clk_in;
  always @(posedge clk_in) cyc_cnt <= cyc_cnt + 1;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t ns: saw %h wanted %h", $time, got, exp);
    end
  endtask : chk
  // small slack for the registered detect and status stages
  function automatic logic [7:0] near(input int got, input int want);
    return {7'h0, got >= want - 3 && got <= want + 5};
  endfunction : near
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= v;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
    chk(d, exp);
  endtask : rchk
  task automatic t_reset;
    rchk(8'hF2, 8'h00);
    rchk(8'hF3, 8'h00);
    rchk(8'hF6, 8'h00);
    rchk(8'hF1, 8'h00);
    rchk(8'hA5, 8'h00);
    chk({5'h0, sw}, 8'h04);
  endtask : t_reset
  task automatic t_config;
    wr(8'hF3, 8'hFF);
    wr(8'hF6, 8'hFF);
    rchk(8'hF3, 8'h3F);
    rchk(8'hF6, 8'h0F);
    for (int i = 0; i < 16; i++) begin
      wr(8'hF6, 8'(i));
      wr(8'hF3, 8'(((i % 4) << 4) | i));
      cyc(2);
      chk({sc_code, lv_code}, 8'(i * 17));
      chk({6'h0, dl_code}, 8'(i % 4));
    end
  endtask : t_config
  task automatic t_fet;
    wr(8'hF1, 8'h06);
    cyc(2);
    chk({5'h0, drv}, 8'h07);
    // charge and discharge on first, then precharge off
    wr(8'hF1, 8'h07);
    cyc(2);
    chk({5'h0, drv}, 8'h03);
    // no current flows in the model, so cutting discharge here is safe
    wr(8'hF1, 8'h03);
    cyc(2);
    chk({5'h0, drv}, 8'h01);
    wr(8'hF1, 8'h30);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_in) pwm <= i[0];
      cyc(3);
      chk({5'h0, drv}, {5'h0, i[0], 1'b0, i[0]});
    end
    @(posedge clk_in) pwm <= 1'b0;
  endtask : t_fet
  // one protection source: flag, masking, refusal, clear, hold-off span
  task automatic t_event(input int k);
    @(posedge clk_in) gie <= 1'b1;
    wr(8'hF1, 8'h06);
    wr(8'hF2, 8'h00);
    @(posedge clk_in) act[k] <= 1'b1;
    t0 = cyc_cnt;
    cyc(3);
    chk({7'h0, irq}, 8'h00);
    rchk(8'hF1, 8'h08);
    rchk(8'hF2, 8'h40 >> k);
    wr(8'hF2, 8'h0F);
    wr(8'hF1, 8'h06);
    cyc(2);
    chk({7'h0, irq}, 8'h01);
    chk({5'h0, drv}, 8'h04);
    rchk(8'hF2, (8'h40 >> k) | 8'h0F);
    @(posedge clk_in) gie <= 1'b0;
    cyc(2);
    chk({7'h0, irq}, 8'h00);
    @(posedge clk_in) gie <= 1'b1;
    wr(8'hF2, (8'h40 >> k) | 8'h0F);
    cyc(2);
    chk({7'h0, irq}, 8'h00);
    @(posedge clk_in) act[k] <= 1'b0;
    while (cp && cyc_cnt - t0 < 20000) cyc(1);
    chk(near(cyc_cnt - t0, 1000 * MS), 8'h01);
    wr(8'hF1, 8'h06);
    cyc(2);
    chk({5'h0, drv}, 8'h07);
  endtask : t_event
  // supply held low: early warning 250 ms before the end, trip at the end
  task automatic t_uv(input int c);
    int w;
    w = (750 + 250 * c) * MS;
    wr(8'hF2, 8'hF0);
    wr(8'hF3, 8'(c << 4));
    @(posedge clk_in) low <= 1'b1;
    t0 = cyc_cnt;
    cyc(w - 250 * MS - 10);
    rchk(8'hF2, 8'h00);
    cyc(10);
    rchk(8'hF2, 8'h80);
    chk({7'h0, irq}, 8'h00);
    wr(8'hF2, 8'h08);
    cyc(2);
    chk({7'h0, irq}, 8'h01);
    while (!trip && cyc_cnt - t0 < 20000) cyc(1);
    chk(near(cyc_cnt - t0, w), 8'h01);
    @(posedge clk_in) low <= 1'b0;
    wr(8'hF2, 8'h88);
    cyc(2);
    chk({6'h0, trip, irq}, 8'h00);
  endtask : t_uv
  task automatic t_power;
    wr(8'hF1, 8'h06);
    @(posedge clk_in) poff <= 1'b1;
    cyc(2);
    chk({2'h0, sw, drv}, 8'h00);
    @(posedge clk_in) poff <= 1'b0;
    cyc(3);
    chk({5'h0, drv}, 8'h04);
  endtask : t_power
  task automatic t_lock;
    wr(8'hF3, 8'h05);
    wr(8'hF6, 8'h0A);
    wr(8'hF0, 8'h01);
    wr(8'hF0, 8'h03);
    rchk(8'hF0, 8'h02);
    cyc(4);
    wr(8'hF0, 8'h01);
    cyc(2);
    chk({7'h0, lck}, 8'h00);
    wr(8'hF0, 8'h03);
    wr(8'hF0, 8'h01);
    wr(8'hF3, 8'h3F);
    wr(8'hF6, 8'h0F);
    cyc(2);
    chk({lck, 3'h0, sc_code}, 8'h8A);
    rchk(8'hF3, 8'h05);
    rchk(8'hF0, 8'h01);
    @(posedge clk_in) rst_in <= 1'b1;
    cyc(5);
    @(posedge clk_in) rst_in <= 1'b0;
    cyc(2);
    chk({7'h0, lck}, 8'h00);
  endtask : t_lock
  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results
  initial begin
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    cyc(2);
    t_reset;
    t_config;
    t_fet;
    for (int k = 0; k < 3; k++) t_event(k);
    for (int c = 0; c < 4; c++) t_uv(c);
    t_power;
    t_lock;
    results;
  end
  // whole run is near 75k clocks; stop well past that
  initial begin
    #400000;
    bad_count++;
    results;
  end
endmodule : bp_fet_ctrl_tb
`default_nettype wire
